/* core/triple_timer.sv */
// Three 16-bit programmable timers with register port
`timescale 1ns/10ps
`default_nettype none
module triple_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic bus_wait,
  // Timer pins
  input wire logic [1:0] timer_in,
  output logic [1:0] timer_out,
  // Interrupt requests
  output logic [2:0] timer_irq
);

  timer_pkg::top_state_t state_reg;
  timer_pkg::top_state_t state_next;
  timer_pkg::reg_sel_t sel_dec;
  logic [1:0] take;
  logic [1:0] pin_level;
  logic [1:0] pin_rise;
  logic [2:0] level_v;
  logic [2:0] rise_v;
  logic [2:0] chain_v;
  logic [2:0] max_evt;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic timer_pkg::reg_sel_t decode(input logic [7:0] a);
    timer_pkg::reg_sel_t d;
    d = '{hit: 1'b1, tmr: 2'd0, kind: timer_pkg::KIND_COUNT};
    case (a)
      timer_pkg::OFS_T0_COUNT: d.kind = timer_pkg::KIND_COUNT;
      timer_pkg::OFS_T0_LIM_A: d.kind = timer_pkg::KIND_LIM_A;
      timer_pkg::OFS_T0_LIM_B: d.kind = timer_pkg::KIND_LIM_B;
      timer_pkg::OFS_T0_MODE: d.kind = timer_pkg::KIND_MODE;
      timer_pkg::OFS_T1_COUNT: d = '{1'b1, 2'd1, timer_pkg::KIND_COUNT};
      timer_pkg::OFS_T1_LIM_A: d = '{1'b1, 2'd1, timer_pkg::KIND_LIM_A};
      timer_pkg::OFS_T1_LIM_B: d = '{1'b1, 2'd1, timer_pkg::KIND_LIM_B};
      timer_pkg::OFS_T1_MODE: d = '{1'b1, 2'd1, timer_pkg::KIND_MODE};
      timer_pkg::OFS_T2_COUNT: d = '{1'b1, 2'd2, timer_pkg::KIND_COUNT};
      timer_pkg::OFS_T2_LIM_A: d = '{1'b1, 2'd2, timer_pkg::KIND_LIM_A};
      timer_pkg::OFS_T2_MODE: d = '{1'b1, 2'd2, timer_pkg::KIND_MODE};
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction

  function automatic logic [15:0] mode_word(input timer_pkg::timer_t t);
    logic [15:0] w;
    w = 16'h0000;
    w[timer_pkg::BIT_EN] = t.en;
    w[timer_pkg::BIT_IRQ_EN] = t.irq_en;
    w[timer_pkg::BIT_SEL] = t.sel;
    w[timer_pkg::BIT_MAX] = t.maxf;
    w[timer_pkg::BIT_RESTART] = t.restart;
    w[timer_pkg::BIT_CHAIN] = t.chain;
    w[timer_pkg::BIT_OUTSIDE] = t.outside;
    w[timer_pkg::BIT_DUAL] = t.dual;
    w[timer_pkg::BIT_FREE] = t.free;
    return w;
  endfunction

  // ----------------------------------------
  // Pin samplers
  // ----------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_pin
    timer_pin_sampler u_pin (
      .clock(clock),
      .reset_n(reset_n),
      .pin(timer_in[p]),
      .take(take[p]),
      .level(pin_level[p]),
      .rise(pin_rise[p])
    );
  end

  assign sel_dec = decode(reg_addr);
  assign level_v = {1'b1, pin_level};
  assign rise_v = {1'b0, pin_rise};
  assign chain_v = {1'b0, state_reg.chain_pend};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] lim;
    logic [15:0] inc;
    logic go;
    logic tick;
    logic t2_tick;
    lim = 16'h0000;
    inc = 16'h0000;
    go = 1'b0;
    tick = 1'b0;
    t2_tick = 1'b0;
    state_next = state_reg;
    state_next.irq = 3'h0;
    state_next.rdata = 16'h0000;
    state_next.wait_st = reg_write | reg_read;
    take = 2'b00;
    max_evt = 3'h0;
    // Shared service slot: timers 0, 1, 2 in turn, then one idle clock
    case (state_reg.slot)
      timer_pkg::SLOT_T0: state_next.slot = timer_pkg::SLOT_T1;
      timer_pkg::SLOT_T1: state_next.slot = timer_pkg::SLOT_T2;
      timer_pkg::SLOT_T2: state_next.slot = timer_pkg::SLOT_IDLE;
      default: state_next.slot = timer_pkg::SLOT_T0;
    endcase
    for (int i = 0; i < 3; i++) begin
      lim = state_reg.tmr[i].sel ? state_reg.tmr[i].lim_b : state_reg.tmr[i].lim_a;
      go = 1'b0;
      if (state_reg.slot == timer_pkg::slot_t'(i[1:0])) begin
        if (i < 2) begin
          take[i[0]] = 1'b1;
        end
        if (state_reg.tmr[i].en) begin
          tick = state_reg.tmr[i].restart ? state_reg.tmr[i].armed : level_v[i];
          if (state_reg.tmr[i].chain) begin
            tick = tick & chain_v[i];
          end
          if (state_reg.tmr[i].outside) begin
            go = rise_v[i];
          end else if (state_reg.tmr[i].restart && rise_v[i]) begin
            state_next.tmr[i].count = 16'h0000;
            state_next.tmr[i].armed = 1'b1;
          end else begin
            go = tick;
          end
        end
      end
      if (go) begin
        inc = state_reg.tmr[i].count + 16'h0001;
        if (inc == lim) begin
          state_next.tmr[i].count = 16'h0000;
          max_evt[i] = 1'b1;
          state_next.tmr[i].maxf = 1'b1;
          state_next.irq[i] = state_reg.tmr[i].irq_en;
          state_next.tmr[i].sel = ~state_reg.tmr[i].sel;
          if (!state_reg.tmr[i].free && (!state_reg.tmr[i].dual || state_reg.tmr[i].sel)) begin
            state_next.tmr[i].en = 1'b0;
          end
        end else begin
          state_next.tmr[i].count = inc;
        end
      end
    end
    t2_tick = max_evt[2];
    for (int j = 0; j < 2; j++) begin
      state_next.chain_pend[j] = (state_reg.chain_pend[j] & ~take[j]) | t2_tick;
    end
    // Register writes, after counting so a write wins, except over a max flag set by counting in the same cycle
    if (reg_write && sel_dec.hit) begin
      case (sel_dec.kind)
        timer_pkg::KIND_COUNT: state_next.tmr[sel_dec.tmr].count = reg_wdata;
        timer_pkg::KIND_LIM_A: state_next.tmr[sel_dec.tmr].lim_a = reg_wdata;
        timer_pkg::KIND_LIM_B: state_next.tmr[sel_dec.tmr].lim_b = reg_wdata;
        timer_pkg::KIND_MODE: begin
          if (reg_wdata[timer_pkg::BIT_WMASK]) begin
            state_next.tmr[sel_dec.tmr].en = reg_wdata[timer_pkg::BIT_EN];
            state_next.tmr[sel_dec.tmr].armed = 1'b0;
          end
          state_next.tmr[sel_dec.tmr].irq_en = reg_wdata[timer_pkg::BIT_IRQ_EN];
          state_next.tmr[sel_dec.tmr].maxf = reg_wdata[timer_pkg::BIT_MAX] |
                                             max_evt[sel_dec.tmr];
          state_next.tmr[sel_dec.tmr].restart = reg_wdata[timer_pkg::BIT_RESTART];
          state_next.tmr[sel_dec.tmr].chain = reg_wdata[timer_pkg::BIT_CHAIN];
          state_next.tmr[sel_dec.tmr].outside = reg_wdata[timer_pkg::BIT_OUTSIDE];
          state_next.tmr[sel_dec.tmr].dual = reg_wdata[timer_pkg::BIT_DUAL];
          state_next.tmr[sel_dec.tmr].free = reg_wdata[timer_pkg::BIT_FREE];
        end
        default: state_next.slot = state_next.slot;
      endcase
    end
    // Timer 2 fixed fields
    state_next.tmr[2].restart = 1'b0;
    state_next.tmr[2].chain = 1'b0;
    state_next.tmr[2].outside = 1'b0;
    state_next.tmr[2].dual = 1'b0;
    state_next.tmr[2].lim_b = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      state_next.tmr[i].sel = state_next.tmr[i].sel & state_next.tmr[i].dual;
    end
    for (int j = 0; j < 2; j++) begin
      state_next.out[j] = state_next.tmr[j].dual ? ~state_next.tmr[j].sel :
                          ~max_evt[j];
    end
    // Read data in the following cycle
    if (reg_read && sel_dec.hit) begin
      case (sel_dec.kind)
        timer_pkg::KIND_COUNT: state_next.rdata = state_reg.tmr[sel_dec.tmr].count;
        timer_pkg::KIND_LIM_A: state_next.rdata = state_reg.tmr[sel_dec.tmr].lim_a;
        timer_pkg::KIND_LIM_B: state_next.rdata = state_reg.tmr[sel_dec.tmr].lim_b;
        default: state_next.rdata = mode_word(state_reg.tmr[sel_dec.tmr]);
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= timer_pkg::RST_TOP;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign bus_wait = state_reg.wait_st;
  assign timer_out = state_reg.out;
  assign timer_irq = state_reg.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  logic wr_t0_mode;
  logic wr_t0;
  assign wr_t0 = reg_write && sel_dec.hit && sel_dec.tmr == 2'd0;
  assign wr_t0_mode = wr_t0 && sel_dec.kind == timer_pkg::KIND_MODE;

  logic wr_t1;
  logic wr_t1_mode;
  logic rd_mode;
  assign wr_t1 = reg_write && sel_dec.hit && sel_dec.tmr == 2'd1;
  assign wr_t1_mode = wr_t1 && sel_dec.kind == timer_pkg::KIND_MODE;
  assign rd_mode = reg_read && sel_dec.hit && sel_dec.kind == timer_pkg::KIND_MODE;

  chk_en_clear_hold: assert property (
    !state_reg.tmr[0].en && !wr_t0 |=> $stable(state_reg.tmr[0].count))
    else $error("timer 0 counted while disabled");
  chk_halt_at_max: assert property (
    max_evt[0] && !state_reg.tmr[0].free && !state_reg.tmr[0].dual && !wr_t0_mode
    |=> !state_reg.tmr[0].en)
    else $error("enable not cleared at maximum");
  chk_mask_keeps_en: assert property (
    wr_t0_mode && !reg_wdata[timer_pkg::BIT_WMASK] && !max_evt[0]
    |=> $stable(state_reg.tmr[0].en))
    else $error("enable changed without write mask");
  chk_irq_cause: assert property (
    timer_irq[0] |-> $past(max_evt[0]) && $past(state_reg.tmr[0].irq_en))
    else $error("interrupt without terminal count");
  chk_irq_pulse: assert property (
    timer_irq[1] |=> !timer_irq[1])
    else $error("interrupt longer than one cycle");
  chk_sel_zero: assert property (
    !state_reg.tmr[1].dual |-> !state_reg.tmr[1].sel)
    else $error("select flag set without dual mode");
  chk_max_flag: assert property (
    max_evt[0] |=> state_reg.tmr[0].maxf &&
    (state_reg.tmr[0].count == 16'h0000 || $past(wr_t0)))
    else $error("max flag or zero count missing");
  chk_out_pulse: assert property (
    max_evt[0] && !state_reg.tmr[0].dual && !wr_t0_mode |=> timer_out[0] == 1'b0 ##1
    timer_out[0] == 1'b1)
    else $error("output pulse wrong");
  chk_slot_only: assert property (
    state_reg.slot != timer_pkg::SLOT_T0 && !wr_t0 |=> $stable(state_reg.tmr[0].count))
    else $error("timer 0 changed outside its slot");
  chk_wait_state: assert property (
    reg_read || reg_write |=> bus_wait)
    else $error("wait state missing");
  chk_mask_reads_zero: assert property (
    rd_mode |=> !reg_rdata[timer_pkg::BIT_WMASK])
    else $error("write mask read back as one");
  chk_t2_fixed_bits: assert property (
    rd_mode && sel_dec.tmr == 2'd2 |=> (reg_rdata & 16'h101e) == 16'h0000)
    else $error("timer 2 fixed mode bits not zero");
  chk_gate_low_hold: assert property (
    state_reg.tmr[0].en && !state_reg.tmr[0].outside && !state_reg.tmr[0].restart &&
    !level_v[0] && !wr_t0 |=> $stable(state_reg.tmr[0].count))
    else $error("gated timer counted with pin low");
  chk_restart_clear: assert property (
    state_reg.slot == timer_pkg::SLOT_T0 && state_reg.tmr[0].en &&
    state_reg.tmr[0].restart && !state_reg.tmr[0].outside && rise_v[0] && !wr_t0
    |=> state_reg.tmr[0].count == 16'h0000)
    else $error("rising edge did not restart count");
  chk_outside_step: assert property (
    state_reg.slot == timer_pkg::SLOT_T1 && state_reg.tmr[1].en &&
    state_reg.tmr[1].outside && rise_v[1] && !wr_t1
    |=> state_reg.tmr[1].count == $past(state_reg.tmr[1].count) + 16'h0001 ||
    state_reg.tmr[1].count == 16'h0000)
    else $error("outside edge not counted");
  chk_chain_hold: assert property (
    state_reg.tmr[1].chain && !state_reg.tmr[1].outside && !state_reg.tmr[1].restart &&
    !chain_v[1] && !wr_t1 |=> $stable(state_reg.tmr[1].count))
    else $error("chained timer counted without timer 2 event");
  chk_dual_to_b: assert property (
    max_evt[1] && state_reg.tmr[1].dual && !state_reg.tmr[1].sel && !wr_t1_mode
    |=> state_reg.tmr[1].sel && state_reg.tmr[1].en)
    else $error("dual mode did not switch to limit B");
  chk_dual_halt_b: assert property (
    max_evt[1] && state_reg.tmr[1].dual && state_reg.tmr[1].sel &&
    !state_reg.tmr[1].free && !wr_t1_mode |=> !state_reg.tmr[1].en && !state_reg.tmr[1].sel)
    else $error("dual mode did not halt after limit B");
  chk_out_dual: assert property (
    state_reg.tmr[1].dual |-> timer_out[1] == !state_reg.tmr[1].sel)
    else $error("output does not show limit in use");
  chk_count_write: assert property (
    wr_t1 && sel_dec.kind == timer_pkg::KIND_COUNT
    |=> state_reg.tmr[1].count == $past(reg_wdata))
    else $error("count write lost");
  chk_irq_t2: assert property (
    max_evt[2] && state_reg.tmr[2].irq_en |=> timer_irq[2])
    else $error("timer 2 terminal count without request");
  chk_t1_idle_hold: assert property (
    !state_reg.tmr[1].en && !wr_t1 |=> $stable(state_reg.tmr[1].count))
    else $error("timer 1 counted while disabled");
  chk_t1_max_flag: assert property (
    max_evt[1] |=> state_reg.tmr[1].maxf)
    else $error("timer 1 max flag missing");

  cov_t0_max: cover property (max_evt[0] && state_reg.tmr[0].irq_en);
  cov_dual_b: cover property (max_evt[1] && state_reg.tmr[1].sel);
  cov_restart: cover property (state_reg.tmr[0].restart && rise_v[0] && state_reg.tmr[0].en);
  cov_chain: cover property (state_reg.tmr[0].chain && max_evt[0]);

endmodule // triple_timer
`default_nettype wire

/* core/timer_pkg.sv */
// Package: register map, mode bits, state types of the three-timer unit
package timer_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_T0_COUNT = 8'h50;
  localparam logic [7:0] OFS_T0_LIM_A = 8'h52;
  localparam logic [7:0] OFS_T0_LIM_B = 8'h54;
  localparam logic [7:0] OFS_T0_MODE = 8'h56;
  localparam logic [7:0] OFS_T1_COUNT = 8'h58;
  localparam logic [7:0] OFS_T1_LIM_A = 8'h5a;
  localparam logic [7:0] OFS_T1_LIM_B = 8'h5c;
  localparam logic [7:0] OFS_T1_MODE = 8'h5e;
  localparam logic [7:0] OFS_T2_COUNT = 8'h60;
  localparam logic [7:0] OFS_T2_LIM_A = 8'h62;
  localparam logic [7:0] OFS_T2_MODE = 8'h66;

  // ----------------------------------------
  // Mode/control bit positions
  // ----------------------------------------
  localparam int BIT_EN = 15;
  localparam int BIT_WMASK = 14;
  localparam int BIT_IRQ_EN = 13;
  localparam int BIT_SEL = 12;
  localparam int BIT_MAX = 5;
  localparam int BIT_RESTART = 4;
  localparam int BIT_CHAIN = 3;
  localparam int BIT_OUTSIDE = 2;
  localparam int BIT_DUAL = 1;
  localparam int BIT_FREE = 0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SLOT_T0 = 2'b00,
    SLOT_T1 = 2'b01,
    SLOT_T2 = 2'b10,
    SLOT_IDLE = 2'b11
  } slot_t;

  typedef enum logic [1:0] {
    KIND_COUNT = 2'b00,
    KIND_LIM_A = 2'b01,
    KIND_LIM_B = 2'b10,
    KIND_MODE = 2'b11
  } reg_kind_t;

  typedef struct packed {
    logic hit;
    logic [1:0] tmr;
    reg_kind_t kind;
  } reg_sel_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] lim_a;
    logic [15:0] lim_b;
    logic en;
    logic irq_en;
    logic sel;
    logic maxf;
    logic restart;
    logic chain;
    logic outside;
    logic dual;
    logic free;
    logic armed;
  } timer_t;

  typedef struct packed {
    timer_t [2:0] tmr;
    slot_t slot;
    logic [1:0] chain_pend;
    logic [15:0] rdata;
    logic wait_st;
    logic [1:0] out;
    logic [2:0] irq;
  } top_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pend;
  } pin_state_t;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam timer_t RST_TMR_DUAL = '{dual: 1'b1, default: '0};
  localparam timer_t RST_TMR_PLAIN = '{default: '0};
  localparam logic [1:0] RST_OUT = 2'b11;
  localparam top_state_t RST_TOP = '{
    tmr: {RST_TMR_PLAIN, RST_TMR_DUAL, RST_TMR_DUAL},
    slot: SLOT_T0,
    chain_pend: 2'b00,
    rdata: 16'h0000,
    wait_st: 1'b0,
    out: RST_OUT,
    irq: 3'h0
  };
  localparam pin_state_t RST_PIN = '{default: '0};

endpackage

/* core/timer_pin_sampler.sv */
// Synchroniser and rising-edge catcher for one timer input pin
`timescale 1ns/10ps
`default_nettype none
module timer_pin_sampler (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Pin side
  input wire logic pin,
  // Timer side
  input wire logic take,
  output logic level,
  output logic rise
);

  timer_pkg::pin_state_t state_reg;
  timer_pkg::pin_state_t state_next;

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.s1 = pin;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    // Edge held until serviced, new edge beats consume
    state_next.pend = (state_reg.pend & ~take) | (state_reg.s2 & ~state_reg.s3);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= timer_pkg::RST_PIN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.s2;
  assign rise = state_reg.pend;

endmodule // timer_pin_sampler
`default_nettype wire

/* tb/timer_pin_partner.sv */
// Event source and output load model for the two timer pins
`timescale 1ns/10ps
`default_nettype none
module timer_pin_partner (
  // Clock
  input wire logic clock,
  // Pins
  input wire logic [1:0] timer_out,
  output logic [1:0] timer_in
);
  int low_cnt [2];

  initial begin
    timer_in = 2'b00;
    low_cnt = '{0, 0};
  end

  // ----------------------------------------
  // Load: clocks seen with output low
  // ----------------------------------------
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      if (timer_out[i] === 1'b0) begin
        low_cnt[i] <= low_cnt[i] + 1;
      end
    end
  end

  task automatic clear_lows();
    low_cnt = '{0, 0};
  endtask

  // ----------------------------------------
  // Source: levels and rising edges
  // ----------------------------------------
  task automatic set_level(input int i, input logic v);
    @(posedge clock);
    timer_in[i] <= v;
  endtask

  // Rising edges gap clocks apart, each pulse high for gap/2 clocks
  task automatic edges(input int i, input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      @(posedge clock);
      timer_in[i] <= 1'b1;
      repeat (gap / 2) @(posedge clock);
      timer_in[i] <= 1'b0;
      repeat (gap - gap / 2 - 1) @(posedge clock);
    end
  endtask
endmodule // timer_pin_partner
`default_nettype wire

/* tb/triple_timer_bench.sv */
// Self-checking bench for the three-timer unit
`timescale 1ns/10ps
`default_nettype none
module triple_timer_bench;
  localparam int LIMIT = 5000;
  logic clock;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic bus_wait;
  logic [1:0] timer_in;
  logic [1:0] timer_out;
  logic [2:0] timer_irq;
  logic [2:0] irq_q;
  logic [15:0] rv;
  int errors;
  int checked;
  int cycles;
  int irq_rise [3];
  int irq_high;

  triple_timer triple_timer_inst (
    .clock(clock),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .bus_wait(bus_wait),
    .timer_in(timer_in),
    .timer_out(timer_out),
    .timer_irq(timer_irq)
  );

  timer_pin_partner timer_pin_partner_inst (
    .clock(clock),
    .timer_out(timer_out),
    .timer_in(timer_in)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------
  // Request pulse counting and timeout
  // ----------------------------------------
  always @(posedge clock) begin
    irq_q <= timer_irq;
    cycles <= cycles + 1;
    if (timer_irq[0] === 1'b1) begin
      irq_high <= irq_high + 1;
    end
    for (int i = 0; i < 3; i++) begin
      if (timer_irq[i] === 1'b1 && irq_q[i] !== 1'b1) begin
        irq_rise[i] <= irq_rise[i] + 1;
      end
    end
    if (cycles == LIMIT) begin
      errors = errors + 1;
      $display("mismatch at %0t: timeout", $time);
      close_out();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
    cmp_bit(bus_wait, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    rv = reg_rdata;
    cmp_bit(bus_wait, 1'b1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    cmp16(rv, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic clear_counts();
    irq_rise = '{0, 0, 0};
    irq_high = 0;
    timer_pin_partner_inst.clear_lows();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    errors = 0;
    checked = 0;
    cycles = 0;
    irq_rise = '{0, 0, 0};
    irq_high = 0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    cmp16({14'h0000, timer_out}, 16'h0003);
    rd_chk(timer_pkg::OFS_T0_MODE, 16'h0002);
    rd_chk(timer_pkg::OFS_T1_MODE, 16'h0002);
    rd_chk(timer_pkg::OFS_T2_MODE, 16'h0000);
    rd_chk(8'h64, 16'h0000);
    wr(timer_pkg::OFS_T0_MODE, 16'h9001);
    rd_chk(timer_pkg::OFS_T0_MODE, 16'h0001);
    wr(timer_pkg::OFS_T2_MODE, 16'hffff);
    rd_chk(timer_pkg::OFS_T2_MODE, 16'ha021);
    wr(timer_pkg::OFS_T2_MODE, 16'h4000);
    rd_chk(timer_pkg::OFS_T2_MODE, 16'h0000);
    wr(timer_pkg::OFS_T0_COUNT, 16'hbeef);
    rd_chk(timer_pkg::OFS_T0_COUNT, 16'hbeef);
    // Single limit, halt at maximum
    timer_pin_partner_inst.set_level(0, 1'b1);
    wr(timer_pkg::OFS_T0_COUNT, 16'h0000);
    wr(timer_pkg::OFS_T0_LIM_A, 16'h0003);
    clear_counts();
    wr(timer_pkg::OFS_T0_MODE, 16'he000);
    idle(40);
    cmp16(16'(irq_rise[0]), 16'h0001);
    cmp16(16'(irq_high), 16'h0001);
    cmp16(16'(timer_pin_partner_inst.low_cnt[0]), 16'h0001);
    rd_chk(timer_pkg::OFS_T0_MODE, 16'h2020);
    rd_chk(timer_pkg::OFS_T0_COUNT, 16'h0000);
    wr(timer_pkg::OFS_T0_MODE, 16'h2000);
    rd_chk(timer_pkg::OFS_T0_MODE, 16'h2000);
    // Gated counting
    timer_pin_partner_inst.set_level(0, 1'b0);
    wr(timer_pkg::OFS_T0_LIM_A, 16'h0100);
    wr(timer_pkg::OFS_T0_MODE, 16'hc001);
    idle(40);
    rd_chk(timer_pkg::OFS_T0_COUNT, 16'h0000);
    timer_pin_partner_inst.set_level(0, 1'b1);
    idle(40);
    rd(timer_pkg::OFS_T0_COUNT);
    cmp_bit(rv >= 16'h0008 && rv <= 16'h000c, 1'b1);
    // Limit below count, then count rewritten
    wr(timer_pkg::OFS_T0_COUNT, 16'h0010);
    wr(timer_pkg::OFS_T0_LIM_A, 16'h0005);
    idle(20);
    rd(timer_pkg::OFS_T0_COUNT);
    cmp_bit(rv > 16'h0010, 1'b1);
    wr(timer_pkg::OFS_T0_COUNT, 16'hfffe);
    idle(40);
    rd(timer_pkg::OFS_T0_COUNT);
    cmp_bit(rv < 16'h0005, 1'b1);
    // Retrigger on rising edges
    wr(timer_pkg::OFS_T0_MODE, 16'h4000);
    timer_pin_partner_inst.set_level(0, 1'b0);
    wr(timer_pkg::OFS_T0_COUNT, 16'h0500);
    wr(timer_pkg::OFS_T0_LIM_A, 16'h1000);
    wr(timer_pkg::OFS_T0_MODE, 16'hc011);
    idle(20);
    rd_chk(timer_pkg::OFS_T0_COUNT, 16'h0500);
    for (int k = 0; k < 2; k++) begin
      timer_pin_partner_inst.edges(0, 1, 8);
      idle(12);
      rd(timer_pkg::OFS_T0_COUNT);
      cmp_bit(rv < 16'h0005, 1'b1);
      idle(40);
    end
    wr(timer_pkg::OFS_T0_MODE, 16'h4000);
    // Outside clock source
    wr(timer_pkg::OFS_T1_COUNT, 16'h0000);
    wr(timer_pkg::OFS_T1_LIM_A, 16'h0100);
    wr(timer_pkg::OFS_T1_MODE, 16'hc005);
    timer_pin_partner_inst.edges(1, 5, 4);
    idle(12);
    rd_chk(timer_pkg::OFS_T1_COUNT, 16'h0005);
    // Chained from timer 2
    wr(timer_pkg::OFS_T1_MODE, 16'h4000);
    wr(timer_pkg::OFS_T2_LIM_A, 16'h0002);
    wr(timer_pkg::OFS_T2_COUNT, 16'h0000);
    wr(timer_pkg::OFS_T1_COUNT, 16'h0000);
    clear_counts();
    timer_pin_partner_inst.set_level(1, 1'b1);
    wr(timer_pkg::OFS_T2_MODE, 16'he001);
    wr(timer_pkg::OFS_T1_MODE, 16'hc009);
    idle(80);
    rd(timer_pkg::OFS_T1_COUNT);
    cmp_bit(rv >= 16'h0008 && rv <= 16'h000b, 1'b1);
    cmp16(16'(irq_rise[2]), 16'h000a);
    wr(timer_pkg::OFS_T2_MODE, 16'h4000);
    // Dual limits, halt after B
    wr(timer_pkg::OFS_T1_MODE, 16'h4000);
    wr(timer_pkg::OFS_T1_COUNT, 16'h0000);
    wr(timer_pkg::OFS_T1_LIM_A, 16'h0002);
    wr(timer_pkg::OFS_T1_LIM_B, 16'h0003);
    clear_counts();
    wr(timer_pkg::OFS_T1_MODE, 16'he002);
    idle(11);
    rd(timer_pkg::OFS_T1_MODE);
    cmp_bit(rv[12], 1'b1);
    cmp_bit(timer_out[1], 1'b0);
    idle(40);
    cmp16(16'(irq_rise[1]), 16'h0002);
    rd_chk(timer_pkg::OFS_T1_MODE, 16'h2022);
    cmp_bit(timer_out[1], 1'b1);
    close_out();
  end
endmodule // triple_timer_bench
`default_nettype wire
